// ===== verilog/pdfs_host.sv
// Controller end: processor-side bus cycles ordered by software over APB.
// Assumes an APB master on clk; device pins are asynchronous to clk.
//
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/10ps
module pdfs_host
  import pdfs_pkg::*;
#(
  parameter int STROBE_CYCLES = PDFS_STROBE_CYCLES,
  parameter int A16_PIN = PDFS_A16_PIN,
  parameter int A17_PIN = PDFS_A17_PIN
) (
  input wire logic clk,
  input wire logic arst_n,
  pdfs_if.host bus,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ---------------------------------------------------------------
  // APB slave and registers
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    PDFS_ST_IDLE = 4'b0001,
    PDFS_ST_SETUP = 4'b0010,
    PDFS_ST_STROBE = 4'b0100,
    PDFS_ST_REC = 4'b1000
  } pdfs_state_t;

  pdfs_state_t state_q;
  logic [31:0] cmd_q;
  logic done_q;
  logic [7:0] rd_q;
  logic [2:0] host_en_q;
  logic pwd_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [7:0] cnt_q;
  logic [2:0] pd_s;

  pdfs_sync #(.W(3), .RST_VAL(3'h7)) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .d(bus.pd),
    .q(pd_s)
  );

  wire setup = psel & ~penable & ~pready_q;
  wire wr = setup & pwrite;
  wire busy = (state_q != PDFS_ST_IDLE);
  wire hit_cmd = (paddr == PDFS_APB_CMD);
  wire hit_go = (paddr == PDFS_APB_GO);
  wire hit_st = (paddr == PDFS_APB_STATUS);
  wire hit_pins = (paddr == PDFS_APB_PINS);
  wire mapped = hit_cmd | hit_go | hit_st | hit_pins;
  wire start = wr & hit_go & pwdata[0] & ~busy;
  wire last = (state_q == PDFS_ST_STROBE) && (cnt_q == 8'(STROBE_CYCLES - 1));
  wire [31:0] rd_mux =
    hit_cmd ? cmd_q :
    hit_st ? {16'h0000, rd_q, 6'h00, done_q, busy} :
    hit_pins ? {21'h000000, pd_s, 4'h0, pwd_q, host_en_q} :
    32'h00000000;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      cmd_q <= 32'h00000000;
      host_en_q <= PDFS_HOST_EN_RST;
      pwd_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~mapped;
      prdata_q <= (setup & ~pwrite) ? rd_mux : 32'h00000000;
      if (wr & hit_cmd & ~busy) cmd_q <= pwdata;
      if (wr & hit_pins) begin
        host_en_q <= pwdata[2:0];
        pwd_q <= pwdata[PDFS_PINS_PWD_BIT];
      end
      // Completion wins over a clear in the same cycle
      if (last) done_q <= 1'b1;
      else if (wr & hit_st & pwdata[PDFS_ST_DONE_BIT]) done_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Bus cycle sequencer
  // ---------------------------------------------------------------
  wire [1:0] space = cmd_q[PDFS_CMD_SPACE_LSB +: 2];
  wire cmd_wr = cmd_q[PDFS_CMD_WRITE_BIT];
  wire strobes_on = (state_q != PDFS_ST_IDLE);
  wire ioms_n_d = ~(strobes_on & (space == PDFS_SP_IO));
  wire dms_n_d = ~(strobes_on & (space == PDFS_SP_DATA));
  wire bms_n_d = ~(strobes_on & (space == PDFS_SP_BDMA));
  wire in_strobe = (state_q == PDFS_ST_STROBE);
  wire [7:0] pc_o_d = (8'(cmd_q[17]) << A17_PIN) | (8'(cmd_q[16]) << A16_PIN);
  wire [7:0] pc_oe_n_d = ~((8'h01 << A17_PIN) | (8'h01 << A16_PIN));

  logic rd_n_q;
  logic wr_n_q;
  logic bms_n_q;
  logic [2:0] pd_o_q;
  logic [2:0] pd_oe_n_q;
  logic [7:0] pc_o_q;
  logic [7:0] pc_oe_n_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= PDFS_ST_IDLE;
      cnt_q <= 8'h00;
      rd_q <= 8'h00;
    end else begin
      case (state_q)
        PDFS_ST_IDLE: begin
          if (start) state_q <= PDFS_ST_SETUP;
        end
        PDFS_ST_SETUP: begin
          state_q <= PDFS_ST_STROBE;
          cnt_q <= 8'h00;
        end
        PDFS_ST_STROBE: begin
          cnt_q <= cnt_q + 8'h01;
          if (last) begin
            state_q <= PDFS_ST_REC;
            if (!cmd_wr) rd_q <= bus.rdata;
          end
        end
        PDFS_ST_REC: begin
          state_q <= PDFS_ST_IDLE;
        end
        default: state_q <= PDFS_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      bms_n_q <= 1'b1;
      pd_o_q <= 3'h3;
      pd_oe_n_q <= 3'h7;
      pc_o_q <= 8'h00;
      pc_oe_n_q <= 8'hFF;
    end else begin
      rd_n_q <= ~(in_strobe & ~last & ~cmd_wr) & ~(state_q == PDFS_ST_SETUP & ~cmd_wr);
      wr_n_q <= ~(in_strobe & ~last & cmd_wr) & ~(state_q == PDFS_ST_SETUP & cmd_wr);
      bms_n_q <= bms_n_d;
      // Strobes on pins zero and one, power-down ack on pin two
      pd_o_q <= {pwd_q, dms_n_d, ioms_n_d};
      pd_oe_n_q <= ~host_en_q;
      pc_o_q <= pc_o_d;
      pc_oe_n_q <= pc_oe_n_d;
    end
  end

  assign bus.addr = cmd_q[15:0];
  assign bus.wdata = cmd_q[PDFS_CMD_WDATA_LSB +: 8];
  assign bus.rd_n = rd_n_q;
  assign bus.wr_n = wr_n_q;
  assign bus.bms_n = bms_n_q;
  assign bus.pd_host_o = pd_o_q;
  assign bus.pd_host_oe_n = pd_oe_n_q;
  assign bus.pc_host_o = pc_o_q;
  assign bus.pc_host_oe_n = pc_oe_n_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

endmodule // pdfs_host

// ===== verilog/pdfs_pkg.sv
// Shared constants for the port D pin function select block and its bus partner.
// Assumes both ends, the checker and the bench import this package.
package pdfs_pkg;

  // ---------------------------------------------------------------
  // Pin function codes
  // ---------------------------------------------------------------
  localparam logic [1:0] PDFS_FN_SWIO = 2'h0;
  localparam logic [1:0] PDFS_FN_LOGIC = 2'h1;
  localparam logic [1:0] PDFS_FN_CSOUT = 2'h2;
  localparam logic [1:0] PDFS_FN_SPECIAL = 2'h3;
  localparam logic [5:0] PDFS_PD_FUNC_RST = {PDFS_FN_SPECIAL, PDFS_FN_LOGIC, PDFS_FN_LOGIC};

  // ---------------------------------------------------------------
  // Device control register block offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] PDFS_OFF_PC_IN = 8'h10;
  localparam logic [7:0] PDFS_OFF_PD_IN = 8'h11;
  localparam logic [7:0] PDFS_OFF_PC_OUT = 8'h12;
  localparam logic [7:0] PDFS_OFF_PD_OUT = 8'h13;
  localparam logic [7:0] PDFS_OFF_PC_DIR = 8'h14;
  localparam logic [7:0] PDFS_OFF_PD_DIR = 8'h15;
  localparam logic [7:0] PDFS_OFF_PAGE = 8'hE0;
  localparam logic [7:0] PDFS_CSIOP_HI = 8'h00;
  localparam logic [1:0] PDFS_WIN_SEG = 2'h0;

  // ---------------------------------------------------------------
  // Port C pin placement
  // ---------------------------------------------------------------
  localparam int PDFS_A16_PIN = 2;
  localparam int PDFS_A17_PIN = 7;
  localparam int PDFS_TEST_PORT_STATUS_PIN = 3;
  localparam int PDFS_TEST_PORT_ERROR_PIN = 4;
  localparam logic [7:0] PDFS_PC_TEST_MASK = 8'h18;

  // ---------------------------------------------------------------
  // Controller APB register map and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] PDFS_APB_CMD = 8'h00;
  localparam logic [7:0] PDFS_APB_GO = 8'h04;
  localparam logic [7:0] PDFS_APB_STATUS = 8'h08;
  localparam logic [7:0] PDFS_APB_PINS = 8'h0C;
  localparam int PDFS_CMD_SPACE_LSB = 18;
  localparam int PDFS_CMD_WRITE_BIT = 20;
  localparam int PDFS_CMD_WDATA_LSB = 24;
  localparam int PDFS_ST_DONE_BIT = 1;
  localparam int PDFS_PINS_PWD_BIT = 3;
  localparam logic [1:0] PDFS_SP_IO = 2'h0;
  localparam logic [1:0] PDFS_SP_DATA = 2'h1;
  localparam logic [1:0] PDFS_SP_BDMA = 2'h2;
  localparam logic [2:0] PDFS_HOST_EN_RST = 3'h7;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int PDFS_CLK_PERIOD_NS = 4;
  localparam int PDFS_STROBE_NS = 24;
  localparam int PDFS_STROBE_CYCLES = (PDFS_STROBE_NS + PDFS_CLK_PERIOD_NS - 1) / PDFS_CLK_PERIOD_NS;

endpackage

// ===== verilog/pdfs_if.sv
// Interface joining the device end and the processor-side controller end.
// Assumes the bench supplies no drivers; pin levels are resolved here with pull-ups.
`timescale 1ns/10ps
interface pdfs_if;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic rd_n;
  logic wr_n;
  logic bms_n;
  logic [2:0] pd_dev_o;
  logic [2:0] pd_dev_oe_n;
  logic [2:0] pd_host_o;
  logic [2:0] pd_host_oe_n;
  logic [2:0] pd;
  logic [7:0] pc_dev_o;
  logic [7:0] pc_dev_oe_n;
  logic [7:0] pc_host_o;
  logic [7:0] pc_host_oe_n;
  logic [7:0] pc;

  // Wire level: device first, then controller, else pulled high
  assign pd = (~pd_dev_oe_n & pd_dev_o) | (pd_dev_oe_n & ~pd_host_oe_n & pd_host_o) | (pd_dev_oe_n & pd_host_oe_n);
  assign pc = (~pc_dev_oe_n & pc_dev_o) | (pc_dev_oe_n & ~pc_host_oe_n & pc_host_o) | (pc_dev_oe_n & pc_host_oe_n);

  modport dev (
    input addr, wdata, rd_n, wr_n, bms_n, pd, pc,
    output rdata, pd_dev_o, pd_dev_oe_n, pc_dev_o, pc_dev_oe_n
  );
  modport host (
    input rdata, pd, pc,
    output addr, wdata, rd_n, wr_n, bms_n, pd_host_o, pd_host_oe_n, pc_host_o, pc_host_oe_n
  );
endinterface // pdfs_if

// ===== verilog/pdfs_sync.sv
// Two-flop synchroniser for pin levels arriving from outside the clock domain.
// Assumes the reset value is a constant given by parameter.
`timescale 1ns/10ps
module pdfs_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // pdfs_sync

// ===== verilog/pdfs_device.sv
// Device end: port D pin function select, control registers and flash segment decode.
// Assumes bus and pin inputs are asynchronous to clk; user-side inputs are on clk.
`timescale 1ns/10ps
module pdfs_device
  import pdfs_pkg::*;
#(
  parameter logic [5:0] PD_FUNC = PDFS_PD_FUNC_RST,
  parameter int A16_PIN = PDFS_A16_PIN,
  parameter int A17_PIN = PDFS_A17_PIN,
  parameter bit TEST_SIX = 1'b1
) (
  input wire logic clk,
  input wire logic arst_n,
  pdfs_if.dev bus,
  input wire logic [2:0] ext_cs_n,
  input wire logic test_port_status,
  input wire logic test_port_error,
  output logic [2:0] logic_in,
  output logic logic_common_clock_in,
  output logic [1:0] addr_hi,
  output logic [7:0] flash_seg
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [15:0] addr_s;
  logic [7:0] wdata_s;
  logic rd_n_s;
  logic wr_n_s;
  logic bms_n_s;
  logic [2:0] pd_s;
  logic [7:0] pc_s;

  pdfs_sync #(.W(38), .RST_VAL({38{1'b1}})) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .d({bus.addr, bus.wdata, bus.rd_n, bus.wr_n, bus.bms_n, bus.pd, bus.pc}),
    .q({addr_s, wdata_s, rd_n_s, wr_n_s, bms_n_s, pd_s, pc_s})
  );

  // ---------------------------------------------------------------
  // Pin roles
  // ---------------------------------------------------------------
  wire [1:0] fn0 = PD_FUNC[1:0];
  wire [1:0] fn1 = PD_FUNC[3:2];
  wire [1:0] fn2 = PD_FUNC[5:4];
  // I/O strobe is read on pin zero whenever it is a logic input or in special role
  wire ioms_n = (fn0 == PDFS_FN_LOGIC || fn0 == PDFS_FN_SPECIAL) ? pd_s[0] : 1'b1;
  // Data strobe only when pin one is a logic input; otherwise byte DMA only
  wire dms_n = (fn1 == PDFS_FN_LOGIC) ? pd_s[1] : 1'b1;
  // Flash select honoured only in special role; else flash always enabled
  wire csi_n = (fn2 == PDFS_FN_SPECIAL) ? pd_s[2] : 1'b0;
  wire clk_pin = (fn1 == PDFS_FN_SPECIAL) & pd_s[1];
  wire a16 = pc_s[A16_PIN];
  wire a17 = pc_s[A17_PIN];

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  logic [2:0] pd_out_q;
  logic [2:0] pd_dir_q;
  logic [7:0] pc_out_q;
  logic [7:0] pc_dir_q;
  logic [2:0] page_q;
  logic wr_n_prev_q;
  logic clk_pin_q;
  logic [7:0] rdata_q;

  wire csiop_sel = ~ioms_n & dms_n & bms_n_s & (addr_s[15:8] == PDFS_CSIOP_HI);
  wire wr_edge = wr_n_prev_q & ~wr_n_s;
  wire reg_wr = csiop_sel & wr_edge;
  wire [7:0] off = addr_s[7:0];
  wire wr_pd_out = reg_wr & (off == PDFS_OFF_PD_OUT);
  wire wr_pd_dir = reg_wr & (off == PDFS_OFF_PD_DIR);
  wire wr_pc_out = reg_wr & (off == PDFS_OFF_PC_OUT);
  wire wr_pc_dir = reg_wr & (off == PDFS_OFF_PC_DIR);
  wire wr_page = reg_wr & (off == PDFS_OFF_PAGE);

  wire [7:0] rdata_mux =
    (off == PDFS_OFF_PD_IN) ? {5'h00, pd_s} :
    (off == PDFS_OFF_PD_OUT) ? {5'h00, pd_out_q} :
    (off == PDFS_OFF_PD_DIR) ? {5'h00, pd_dir_q} :
    (off == PDFS_OFF_PC_IN) ? pc_s :
    (off == PDFS_OFF_PC_OUT) ? pc_out_q :
    (off == PDFS_OFF_PC_DIR) ? pc_dir_q :
    (off == PDFS_OFF_PAGE) ? {5'h00, page_q} :
    8'h00;
  wire [7:0] rdata_d = (csiop_sel & ~rd_n_s) ? rdata_mux : 8'h00;

  // Reset clears every port and configuration register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pd_out_q <= 3'h0;
      pd_dir_q <= 3'h0;
      pc_out_q <= 8'h00;
      pc_dir_q <= 8'h00;
      page_q <= 3'h0;
    end else begin
      if (wr_pd_out) pd_out_q <= wdata_s[2:0];
      if (wr_pd_dir) pd_dir_q <= wdata_s[2:0];
      if (wr_pc_out) pc_out_q <= wdata_s;
      if (wr_pc_dir) pc_dir_q <= wdata_s;
      if (wr_page) page_q <= wdata_s[2:0];
    end
  end

  // Edge detector starts at the pulled-up pin level, so no false edge after reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_n_prev_q <= 1'b1;
      clk_pin_q <= 1'b1;
      rdata_q <= 8'h00;
    end else begin
      wr_n_prev_q <= wr_n_s;
      clk_pin_q <= clk_pin;
      rdata_q <= rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // Flash segment decode
  // ---------------------------------------------------------------
  wire [2:0] bdma_seg = {a16, addr_s[15:14]};
  wire bdma_hit = ioms_n & dms_n & ~bms_n_s;
  wire ovl_hit = ioms_n & ~dms_n & bms_n_s & (addr_s[15:14] == PDFS_WIN_SEG) & ~a17;
  wire [7:0] seg_onehot = 8'h01 << (bdma_hit ? bdma_seg : page_q);
  // Flash fully disabled while its select is high
  wire [7:0] flash_seg_d = (~csi_n & (bdma_hit | ovl_hit)) ? seg_onehot : 8'h00;

  // ---------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------
  logic [2:0] pd_o_d;
  logic [2:0] pd_oe_n_d;
  logic [2:0] pd_o_q;
  logic [2:0] pd_oe_n_q;
  logic [7:0] pc_o_q;
  logic [7:0] pc_oe_n_q;
  logic [7:0] flash_seg_q;
  logic logic_clk_q;

  genvar g;
  for (g = 0; g < 3; g++) begin : g_pd
    wire [1:0] fn = PD_FUNC[2*g +: 2];
    // Chip select straight from logic, no output macrocell used
    assign pd_o_d[g] = (fn == PDFS_FN_CSOUT) ? ext_cs_n[g] : pd_out_q[g];
    assign pd_oe_n_d[g] = ~((fn == PDFS_FN_CSOUT) | ((fn == PDFS_FN_SWIO) & pd_dir_q[g]));
  end

  wire [7:0] pc_test_o = (8'(test_port_error) << PDFS_TEST_PORT_ERROR_PIN) | (8'(test_port_status) << PDFS_TEST_PORT_STATUS_PIN);
  // Status pins become general I/O in four-signal mode
  wire [7:0] pc_o_d = (TEST_SIX ? pc_test_o : pc_out_q) & PDFS_PC_TEST_MASK;
  wire [7:0] pc_oe_n_d = ~(PDFS_PC_TEST_MASK & (TEST_SIX ? 8'hFF : pc_dir_q));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pd_o_q <= 3'h0;
      pd_oe_n_q <= 3'h7;
      pc_o_q <= 8'h00;
      pc_oe_n_q <= 8'hFF;
      flash_seg_q <= 8'h00;
      logic_clk_q <= 1'b0;
    end else begin
      pd_o_q <= pd_o_d;
      pd_oe_n_q <= pd_oe_n_d;
      pc_o_q <= pc_o_d;
      pc_oe_n_q <= pc_oe_n_d;
      flash_seg_q <= flash_seg_d;
      logic_clk_q <= clk_pin & ~clk_pin_q;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign bus.rdata = rdata_q;
  assign bus.pd_dev_o = pd_o_q;
  assign bus.pd_dev_oe_n = pd_oe_n_q;
  assign bus.pc_dev_o = pc_o_q;
  assign bus.pc_dev_oe_n = pc_oe_n_q;
  assign logic_in = pd_s;
  assign logic_common_clock_in = logic_clk_q;
  assign addr_hi = {pc_s[A17_PIN], pc_s[A16_PIN]};
  assign flash_seg = flash_seg_q;

endmodule // pdfs_device

// ===== sim/pdfs_props.sv
// Concurrent checks on the wire joining the device and controller ends.
// Assumes the bench feeds interface signals and device outputs of the first pair.
`timescale 1ns/10ps
module pdfs_props
  import pdfs_pkg::*;
#(
  parameter int A16_PIN = PDFS_A16_PIN,
  parameter int A17_PIN = PDFS_A17_PIN
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic bms_n,
  input wire logic [2:0] pd,
  input wire logic [7:0] pc,
  input wire logic [2:0] pd_dev_oe_n,
  input wire logic [7:0] pc_dev_oe_n,
  input wire logic [2:0] logic_in,
  input wire logic logic_common_clock_in,
  input wire logic [1:0] addr_hi,
  input wire logic [7:0] flash_seg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_strobe_excl: assert property (rd_n || wr_n)
    else $error("read and write strobes low together");
  a_strobe_width: assert property ($fell(rd_n) |=> !rd_n [*5] ##1 rd_n)
    else $error("read strobe width wrong");
  a_strobe_space: assert property (!rd_n || !wr_n |-> !pd[0] || !pd[1] || !bms_n)
    else $error("strobe outside any space select");
  a_logic_follow: assert property (logic_in == $past(pd, 2))
    else $error("logic input does not follow pins");
  a_addr_follow: assert property (addr_hi == $past({pc[A17_PIN], pc[A16_PIN]}, 2))
    else $error("upper address does not follow pins");
  a_pd_input: assert property (pd_dev_oe_n == 3'h7)
    else $error("device drives an input pin");
  a_clk_quiet: assert property (!logic_common_clock_in)
    else $error("clock pulse while pin one is not clock");
  a_flash_off: assert property (pd[2] [*4] |-> flash_seg == 8'h00)
    else $error("flash selected while select input high");
  a_seg_onehot: assert property ($onehot0(flash_seg))
    else $error("more than one flash segment");
  a_test_drive: assert property ($past(arst_n, 2) |-> pc_dev_oe_n[4:3] == 2'h0)
    else $error("status pins not driven");
  c_read: cover property ($fell(rd_n));
  c_write: cover property ($fell(wr_n));
  c_flash: cover property (flash_seg != 8'h00);
endmodule // pdfs_props

// ===== sim/pdfs_tb.sv
// Self-checking bench: APB-driven controller facing the device, plus a device with other pin roles.
// Assumes the design package, interface, both ends and the checker are compiled first.
`timescale 1ns/10ps
module pdfs_tb;
  import pdfs_pkg::*;
  logic clk;
  logic arst_n;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] ext_cs_n;
  logic tp_status;
  logic tp_error;
  logic [2:0] logic_in;
  logic clk_pulse;
  logic [1:0] addr_hi;
  logic [7:0] flash_seg;
  logic [2:0] alt_cs_n;
  logic [2:0] alt_logic_in;
  logic alt_pulse;
  logic [7:0] seg_seen;
  logic [31:0] r;
  logic e;
  int fails = 0;
  int comparisons = 0;
  int alt_pulses = 0;
  logic [15:0] wa [5] = '{16'h0013, 16'h0015, 16'h00E0, 16'h01E0, 16'h0040};
  logic [15:0] ra [5] = '{16'h0013, 16'h0015, 16'h00E0, 16'h00E0, 16'h0040};
  logic [7:0] wv [5] = '{8'h05, 8'h06, 8'h0D, 8'h03, 8'h5A};
  logic [7:0] ev [5] = '{8'h05, 8'h06, 8'h05, 8'h05, 8'h00};
  logic [31:0] fp [5] = '{32'h7, 32'h7, 32'h7, 32'hF, 32'h3};
  logic [1:0] fs [5] = '{PDFS_SP_DATA, PDFS_SP_BDMA, PDFS_SP_DATA, PDFS_SP_DATA, PDFS_SP_DATA};
  logic [17:0] fa [5] = '{18'h00000, 18'h18000, 18'h20000, 18'h00000, 18'h00000};
  logic [7:0] fe [5] = '{8'h20, 8'h40, 8'h00, 8'h00, 8'h00};

  pdfs_if pdfs_if_inst();
  pdfs_if alt_if();
  pdfs_host pdfs_host_inst (.clk(clk), .arst_n(arst_n), .bus(pdfs_if_inst.host), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  pdfs_device pdfs_device_inst (.clk(clk), .arst_n(arst_n), .bus(pdfs_if_inst.dev), .ext_cs_n(ext_cs_n),
    .test_port_status(tp_status), .test_port_error(tp_error), .logic_in(logic_in),
    .logic_common_clock_in(clk_pulse), .addr_hi(addr_hi), .flash_seg(flash_seg));
  pdfs_device #(.PD_FUNC({PDFS_FN_CSOUT, PDFS_FN_SPECIAL, PDFS_FN_CSOUT}), .TEST_SIX(1'b0)) alt_pdfs_device_inst (
    .clk(clk), .arst_n(arst_n), .bus(alt_if.dev), .ext_cs_n(alt_cs_n), .test_port_status(tp_status),
    .test_port_error(tp_error), .logic_in(alt_logic_in), .logic_common_clock_in(alt_pulse), .addr_hi(),
    .flash_seg());
  pdfs_props pdfs_props_inst (.clk(clk), .arst_n(arst_n), .rd_n(pdfs_if_inst.rd_n), .wr_n(pdfs_if_inst.wr_n),
    .bms_n(pdfs_if_inst.bms_n), .pd(pdfs_if_inst.pd), .pc(pdfs_if_inst.pc), .pd_dev_oe_n(pdfs_if_inst.pd_dev_oe_n),
    .pc_dev_oe_n(pdfs_if_inst.pc_dev_oe_n), .logic_in(logic_in), .logic_common_clock_in(clk_pulse),
    .addr_hi(addr_hi), .flash_seg(flash_seg));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Processor bus cycle; read byte lands in r[15:8]
  task automatic dsp(input logic w, input logic [1:0] sp, input logic [17:0] a, input logic [7:0] wd);
    int n = 0;
    @(negedge clk);
    seg_seen = 8'h00;
    apb(1'b1, PDFS_APB_CMD, {wd, 3'h0, w, sp, a});
    apb(1'b1, PDFS_APB_STATUS, 32'h2);
    apb(1'b1, PDFS_APB_GO, 32'h1);
    do begin
      apb(1'b0, PDFS_APB_STATUS, 32'h0);
      n++;
    end while (r[0] !== 1'b0 && n < 50);
    chk({30'h0, r[PDFS_ST_DONE_BIT], r[0]}, 32'h2);
  endtask

  // ---------------------------------------------------------------
  // Clock, monitors and sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    seg_seen <= seg_seen | flash_seg;
    if (alt_pulse === 1'b1) begin
      alt_pulses <= alt_pulses + 1;
    end
  end

  initial begin
    #20000;
    fails++;
    print_verdict();
  end

  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ext_cs_n = 3'h7;
    tp_status = 1'b0;
    tp_error = 1'b1;
    alt_cs_n = 3'h2;
    seg_seen = 8'h00;
    alt_if.addr = 16'h0000;
    alt_if.wdata = 8'h00;
    alt_if.rd_n = 1'b1;
    alt_if.wr_n = 1'b1;
    alt_if.bms_n = 1'b1;
    alt_if.pd_host_o = 3'h0;
    alt_if.pd_host_oe_n = 3'h5;
    alt_if.pc_host_o = 8'h00;
    alt_if.pc_host_oe_n = 8'hFF;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge clk);
    apb(1'b0, PDFS_APB_PINS, 32'h0);
    chk(r, 32'h0000_0307);
    chk({30'h0, addr_hi}, 32'h0);
    dsp(1'b0, PDFS_SP_IO, {10'h000, PDFS_OFF_PD_DIR}, 8'h00);
    chk({24'h0, r[15:8]}, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      dsp(1'b1, PDFS_SP_IO, {2'h0, wa[i]}, wv[i]);
      dsp(1'b0, PDFS_SP_IO, {2'h0, ra[i]}, 8'h00);
      chk({24'h0, r[15:8]}, {24'h0, ev[i]});
    end
    dsp(1'b0, PDFS_SP_IO, {10'h000, PDFS_OFF_PD_IN}, 8'h00);
    chk({24'h0, r[15:8]}, 32'h2);
    dsp(1'b0, PDFS_SP_IO, {2'h1, 8'h00, PDFS_OFF_PC_IN}, 8'h00);
    chk({24'h0, r[15:8]}, 32'h77);
    chk({30'h0, addr_hi}, 32'h1);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    $display("test registers done");
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, PDFS_APB_PINS, fp[i]);
      dsp(1'b0, fs[i], fa[i], 8'h00);
      chk({24'h0, seg_seen}, {24'h0, fe[i]});
    end
    apb(1'b1, PDFS_APB_PINS, 32'h7);
    $display("test flash decode done");
    chk({29'h0, alt_if.pd}, 32'h0);
    @(posedge clk);
    alt_cs_n <= 3'h5;
    repeat (4) @(posedge clk);
    chk({29'h0, alt_if.pd}, 32'h5);
    chk({29'h0, alt_if.pd_dev_oe_n}, 32'h2);
    repeat (4) begin
      @(posedge clk);
      alt_if.pd_host_o[1] <= 1'b1;
      repeat (3) @(posedge clk);
      alt_if.pd_host_o[1] <= 1'b0;
      repeat (3) @(posedge clk);
    end
    repeat (3) @(posedge clk);
    chk(alt_pulses, 32'h4);
    chk({29'h0, alt_logic_in}, 32'h5);
    chk({30'h0, alt_if.pc[4:3]}, 32'h3);
    $display("test pin roles done");
    print_verdict();
  end
endmodule // pdfs_tb
